// *** radio_event_irq_shortcut_ctrl.sv ***
// Radio event shortcuts, interrupt enable mask and AXI4-Lite register slave
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module radio_event_irq_shortcut_ctrl
#(
   parameter int RSSI_W = 7,
   parameter int BCNT_W = 32
)
(
   input wire logic core_clk,
   input wire logic nrst,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Radio datapath, same clock
   input wire logic [31:0] radio_events,
   input wire logic rssi_sample_valid,
   input wire logic [RSSI_W-1:0] rssi_sample,
   input wire logic bit_count_start,
   input wire logic rx_bit_strobe,
   input wire logic lr_rx_begin,
   input wire logic ci_valid,
   input wire logic ci_fast,
   output radio_evt_pkg::radio_task_s radio_tasks,
   output logic rx_rate_high,
   output logic irq
);
   import radio_evt_pkg::*;

   // Refuse widths that one 32-bit register word cannot carry
   if (RSSI_W < 1 || RSSI_W > 32 || BCNT_W < 1 || BCNT_W > 32)
   begin : g_bad_width
      $error("RSSI_W and BCNT_W must lie in 1..32");
   end

   function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
      strobe_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [31:0] bm);
      merge = (old & ~bm) | (nw & bm);
   endfunction

   // ==========================================================
   // Bus state
   logic aw_hold_q, aw_hold_d;
   logic w_hold_q, w_hold_d;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;

   // ==========================================================
   // Block state
   logic [31:0] shortcuts_q, shortcuts_d;
   logic [31:0] int_mask_q, int_mask_d;
   logic [31:0] evt_status_q, evt_status_d;
   logic [BCNT_W-1:0] bit_cmp_q, bit_cmp_d;
   logic [BCNT_W-1:0] bit_cnt_q;
   logic bit_run_q;
   logic [RSSI_W-1:0] rssi_q;
   rate_mode_e rate_q;
   logic rssi_evt_q, bit_evt_q, rate_evt_q;
   radio_task_s tasks_q, tasks_d;
   logic irq_q;

   // ==========================================================
   // Write channel decode
   wire aw_take = s_axi_awvalid & awready_q;
   wire w_take = s_axi_wvalid & wready_q;
   wire wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
   wire [31:0] wbm = strobe_mask(wstrb_q);
   wire [31:0] wmask_data = wdata_q & wbm;
   wire wr_status = wr_go & (awaddr_q == ADDR_EVT_STATUS);
   wire wr_short = wr_go & (awaddr_q == ADDR_SHORTCUTS);
   wire wr_set = wr_go & (awaddr_q == ADDR_INT_SET);
   wire wr_clr = wr_go & (awaddr_q == ADDR_INT_CLR);
   wire wr_bcmp = wr_go & (awaddr_q == ADDR_BIT_CMP);
   wire wr_known = (awaddr_q == ADDR_EVT_STATUS) || (awaddr_q == ADDR_SHORTCUTS) ||
                   (awaddr_q == ADDR_INT_SET) || (awaddr_q == ADDR_INT_CLR) ||
                   (awaddr_q == ADDR_BIT_CMP) || (awaddr_q == ADDR_RSSI_SAMPLE);

   assign aw_hold_d = (aw_hold_q | aw_take) & ~wr_go;
   assign w_hold_d = (w_hold_q | w_take) & ~wr_go;

   // ==========================================================
   // Read channel decode
   wire rd_take = s_axi_arvalid & arready_q;
   wire rd_done = rvalid_q & s_axi_rready;
   wire rvalid_d = rd_take | (rvalid_q & ~rd_done);
   wire [31:0] bcmp_word = 32'(bit_cmp_q);
   wire [31:0] rssi_word = 32'(rssi_q);
   wire rd_known = (s_axi_araddr == ADDR_EVT_STATUS) || (s_axi_araddr == ADDR_SHORTCUTS) ||
                   (s_axi_araddr == ADDR_INT_SET) || (s_axi_araddr == ADDR_INT_CLR) ||
                   (s_axi_araddr == ADDR_BIT_CMP) || (s_axi_araddr == ADDR_RSSI_SAMPLE);
   wire [31:0] rd_word =
      (s_axi_araddr == ADDR_EVT_STATUS) ? evt_status_q :
      (s_axi_araddr == ADDR_SHORTCUTS) ? shortcuts_q :
      (s_axi_araddr == ADDR_INT_SET) ? int_mask_q :
      (s_axi_araddr == ADDR_INT_CLR) ? int_mask_q :
      (s_axi_araddr == ADDR_BIT_CMP) ? bcmp_word :
      (s_axi_araddr == ADDR_RSSI_SAMPLE) ? rssi_word : RST_ZERO;

   // ==========================================================
   // Event collection; the block's own events replace the datapath's lines
   wire [31:0] evt_internal = ({31'h0, rssi_evt_q} << EV_RSSI_DONE) |
                              ({31'h0, bit_evt_q} << EV_BIT_MATCH) |
                              ({31'h0, rate_evt_q} << EV_RATE_UP);
   wire [31:0] evt_now = ((radio_events & ~EVT_INTERNAL) | evt_internal) & EVT_MASK;

   // Set wins over a same-cycle write-one-to-clear so no event is lost
   assign evt_status_d = wr_status ? ((evt_status_q & ~wmask_data) | evt_now)
                                   : (evt_status_q | evt_now);

   // A single mask serves both set and clear registers
   assign int_mask_d = wr_set ? (int_mask_q | (wmask_data & EVT_MASK)) :
                       wr_clr ? (int_mask_q & ~wmask_data) :
                       int_mask_q;

   assign shortcuts_d = wr_short ? (merge(shortcuts_q, wdata_q, wbm) & SC_MASK)
                                 : shortcuts_q;
   wire [31:0] bcmp_merged = merge(bcmp_word, wdata_q, wbm);
   assign bit_cmp_d = wr_bcmp ? bcmp_merged[BCNT_W-1:0] : bit_cmp_q;

   // ==========================================================
   // Shortcuts: tasks fire one cycle after their event
   assign tasks_d.ed_start = shortcuts_q[SC_READY_ED_START] & evt_now[EV_READY];
   assign tasks_d.disable_radio =
      (shortcuts_q[SC_ED_DONE_DISABLE] & evt_now[EV_ED_DONE]) |
      (shortcuts_q[SC_PHY_END_DISABLE] & evt_now[EV_PHY_END]);
   assign tasks_d.stop_radio = shortcuts_q[SC_IDLE_STOP] & evt_now[EV_CHAN_IDLE];
   assign tasks_d.start_radio =
      (shortcuts_q[SC_TX_READY_START] & evt_now[EV_TX_READY]) |
      (shortcuts_q[SC_RX_READY_START] & evt_now[EV_RX_READY]) |
      (shortcuts_q[SC_PHY_END_START] & evt_now[EV_PHY_END]);

   // ==========================================================
   // Bit counter and rate detection
   wire [BCNT_W-1:0] bit_cnt_inc = bit_cnt_q + BCNT_W'(1);
   wire bit_hit = bit_run_q & rx_bit_strobe & ~bit_count_start & (bit_cnt_inc == bit_cmp_q);
   wire rate_step = ci_valid & ci_fast & (rate_q == RATE_LOW) & ~lr_rx_begin;

   // ==========================================================
   // Bus registers
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= RST_ZERO;
         wstrb_q <= 4'h0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= RST_ZERO;
      end
      else
      begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         awready_q <= ~aw_hold_d;
         wready_q <= ~w_hold_d;
         arready_q <= ~rvalid_d;
         rvalid_q <= rvalid_d;
         if (aw_take)
         begin
            awaddr_q <= {s_axi_awaddr[11:2], 2'h0};
         end
         if (w_take)
         begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            bvalid_q <= 1'b0;
         end
         if (rd_take)
         begin
            rdata_q <= rd_word;
            rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ==========================================================
   // Block registers
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         shortcuts_q <= RST_ZERO;
         int_mask_q <= RST_ZERO;
         evt_status_q <= RST_ZERO;
         bit_cmp_q <= '0;
         tasks_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         shortcuts_q <= shortcuts_d;
         int_mask_q <= int_mask_d;
         evt_status_q <= evt_status_d;
         bit_cmp_q <= bit_cmp_d;
         tasks_q <= tasks_d;
         irq_q <= |(evt_status_d & int_mask_d);
      end
   end

   // ==========================================================
   // Internally raised events
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         rssi_q <= '0;
         rssi_evt_q <= 1'b0;
         bit_cnt_q <= '0;
         bit_run_q <= 1'b0;
         bit_evt_q <= 1'b0;
         rate_q <= RATE_LOW;
         rate_evt_q <= 1'b0;
      end
      else
      begin
         rssi_evt_q <= rssi_sample_valid;
         if (rssi_sample_valid)
         begin
            rssi_q <= rssi_sample;
         end
         bit_evt_q <= bit_hit;
         if (bit_count_start)
         begin
            bit_cnt_q <= '0;
            bit_run_q <= 1'b1;
         end
         else if (bit_run_q && rx_bit_strobe)
         begin
            bit_cnt_q <= bit_cnt_inc;
            bit_run_q <= ~bit_hit;
         end
         rate_evt_q <= rate_step;
         if (lr_rx_begin)
         begin
            rate_q <= RATE_LOW;
         end
         else if (rate_step)
         begin
            rate_q <= RATE_HIGH;
         end
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign radio_tasks = tasks_q;
   assign rx_rate_high = (rate_q == RATE_HIGH);
   assign irq = irq_q;

endmodule // radio_event_irq_shortcut_ctrl

// *** radio_event_irq_shortcut_ctrl_tb_top.sv ***
// Directed testbench for the radio event routing block
`timescale 1ns/1ps
module radio_event_irq_shortcut_ctrl_tb_top;
   import radio_evt_pkg::*;
   logic core_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, radio_events, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic rssi_sample_valid, bit_count_start, rx_bit_strobe, lr_rx_begin, ci_valid, ci_fast;
   logic [6:0] rssi_sample;
   radio_task_s radio_tasks;
   logic rx_rate_high, irq;
   int fails, tests_run;
   int ev_bit[7] = '{EV_READY, EV_ED_DONE, EV_CHAN_IDLE, EV_TX_READY, EV_RX_READY,
      EV_PHY_END, EV_PHY_END};
   logic [3:0] task_exp[7] = '{4'h8, 4'h2, 4'h1, 4'h4, 4'h4, 4'h2, 4'h4};

   radio_event_irq_shortcut_ctrl dut
   (
      .core_clk(core_clk),
      .nrst(nrst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .radio_events(radio_events),
      .rssi_sample_valid(rssi_sample_valid),
      .rssi_sample(rssi_sample),
      .bit_count_start(bit_count_start),
      .rx_bit_strobe(rx_bit_strobe),
      .lr_rx_begin(lr_rx_begin),
      .ci_valid(ci_valid),
      .ci_fast(ci_fast),
      .radio_tasks(radio_tasks),
      .rx_rate_high(rx_rate_high),
      .irq(irq)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // ==========================================================
   // Bus and stimulus tasks
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // Ready is raised inside the loop so back-to-back calls never drive it twice at one edge
      do
      begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (!s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
   endtask

   task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (!s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      check(n, e, rd);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic pulse(input int b);
      radio_events <= 32'h1 << b;
      tick(1);
      radio_events <= 32'h0;
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      #100000;
      fails++;
      summarize();
   end

   // ==========================================================
   // Test sequence
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {rssi_sample_valid, bit_count_start, rx_bit_strobe, lr_rx_begin, ci_valid, ci_fast} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, radio_events, rssi_sample} = '0;
      s_axi_wstrb = 4'hf;
      nrst = 1'b0;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      tick(2);
      rchk("set reset", ADDR_INT_SET, RST_ZERO);
      rchk("clear reset", ADDR_INT_CLR, RST_ZERO);
      rchk("shortcut reset", ADDR_SHORTCUTS, RST_ZERO);
      rchk("unmapped data", 12'h7fc, RST_ZERO);
      check("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      pulse(EV_READY);
      check("no shortcut", 32'h0, {28'h0, radio_tasks});
      for (int i = 0; i < 7; i++)
      begin
         wr(ADDR_SHORTCUTS, 32'h1 << (SC_READY_ED_START + i));
         pulse(ev_bit[i]);
         check("task pulse", {28'h0, task_exp[i]}, {28'h0, radio_tasks});
         tick(1);
         check("task ends", 32'h0, {28'h0, radio_tasks});
      end
      wr(ADDR_SHORTCUTS, 32'hffffffff);
      rchk("shortcut rb", ADDR_SHORTCUTS, SC_MASK);
      wr(ADDR_SHORTCUTS, RST_ZERO);
      wr(ADDR_INT_SET, 32'hffffffff);
      check("write resp", {30'h0, RESP_OKAY}, {30'h0, rs});
      rchk("set rb", ADDR_INT_SET, EVT_MASK);
      wr(ADDR_INT_CLR, 32'h00000001);
      wr(ADDR_INT_SET, RST_ZERO);
      rchk("clear rb", ADDR_INT_CLR, EVT_MASK & 32'hfffffffe);
      wr(ADDR_INT_CLR, EVT_MASK);
      rchk("all off", ADDR_INT_SET, RST_ZERO);
      // Only the low byte lane is enabled, so only low-byte events may turn on
      s_axi_wstrb <= 4'h1;
      wr(ADDR_INT_SET, 32'hffffffff);
      s_axi_wstrb <= 4'hf;
      rchk("strobe set", ADDR_INT_SET, EVT_MASK & 32'h000000ff);
      wr(ADDR_INT_CLR, EVT_MASK);
      rchk("strobe clear", ADDR_INT_CLR, RST_ZERO);
      // Status is sticky, so clear it before judging the mask alone
      wr(ADDR_EVT_STATUS, 32'hffffffff);
      pulse(EV_TX_READY);
      tick(1);
      check("masked irq", 32'h0, {31'h0, irq});
      wr(ADDR_INT_SET, 32'h1 << EV_TX_READY);
      tick(2);
      check("irq on", 32'h1, {31'h0, irq});
      wr(ADDR_INT_CLR, 32'h1 << EV_TX_READY);
      tick(2);
      check("irq off", 32'h0, {31'h0, irq});
      wr(ADDR_INT_SET, 32'h1 << EV_TX_READY);
      wr(ADDR_EVT_STATUS, 32'hffffffff);
      tick(2);
      check("status cleared", 32'h0, {31'h0, irq});
      rssi_sample <= 7'h2a;
      rssi_sample_valid <= 1'b1;
      tick(1);
      rssi_sample_valid <= 1'b0;
      tick(3);
      rchk("rssi event", ADDR_EVT_STATUS, 32'h1 << EV_RSSI_DONE);
      rchk("rssi value", ADDR_RSSI_SAMPLE, 32'h2a);
      wr(ADDR_EVT_STATUS, 32'hffffffff);
      wr(ADDR_BIT_CMP, 32'h3);
      bit_count_start <= 1'b1;
      tick(1);
      bit_count_start <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         tick(3);
         rchk("bit match", ADDR_EVT_STATUS, 32'h0);
         rx_bit_strobe <= 1'b1;
         tick(1);
         rx_bit_strobe <= 1'b0;
      end
      tick(3);
      rchk("bit match", ADDR_EVT_STATUS, 32'h1 << EV_BIT_MATCH);
      wr(ADDR_EVT_STATUS, 32'hffffffff);
      lr_rx_begin <= 1'b1;
      tick(1);
      lr_rx_begin <= 1'b0;
      ci_fast <= 1'b1;
      ci_valid <= 1'b1;
      tick(1);
      ci_valid <= 1'b0;
      tick(3);
      check("high rate", 32'h1, {31'h0, rx_rate_high});
      rchk("rate event", ADDR_EVT_STATUS, 32'h1 << EV_RATE_UP);
      summarize();
   end
endmodule // radio_event_irq_shortcut_ctrl_tb_top

bind radio_event_irq_shortcut_ctrl radio_evt_checker chk
(
   .core_clk(core_clk),
   .nrst(nrst),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .radio_events(radio_events),
   .ci_valid(ci_valid),
   .radio_tasks(radio_tasks),
   .rx_rate_high(rx_rate_high),
   .irq(irq)
);

// *** radio_evt_checker.sv ***
// Port-level assertions for the radio event routing block
`timescale 1ns/1ps
module radio_evt_checker
import radio_evt_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] radio_events,
   input wire logic ci_valid,
   input wire radio_evt_pkg::radio_task_s radio_tasks,
   input wire logic rx_rate_high,
   input wire logic irq
);
   // ==========================================================
   // Shortcut tasks only ever follow their own event; rate rise follows ci_valid; irq and tasks quiet after reset
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   AST_ED_START: assert property (radio_tasks.ed_start |-> $past(radio_events[EV_READY]))
      else $error("energy detect start without ready event");
   AST_DISABLE: assert property (radio_tasks.disable_radio |->
      $past(radio_events[EV_ED_DONE] | radio_events[EV_PHY_END]))
      else $error("disable task without its event");
   AST_STOP: assert property (radio_tasks.stop_radio |-> $past(radio_events[EV_CHAN_IDLE]))
      else $error("stop task without channel idle event");
   AST_START: assert property (radio_tasks.start_radio |-> $past(radio_events[EV_TX_READY]
      | radio_events[EV_RX_READY] | radio_events[EV_PHY_END]))
      else $error("start task without its event");
   AST_RATE_UP: assert property ($rose(rx_rate_high) |-> $past(ci_valid) || $past(ci_valid, 2))
      else $error("rate switch without coding indicator");
   AST_RESET_QUIET: assert property ($rose(nrst) |-> !irq && radio_tasks == 4'h0)
      else $error("irq or task active straight after reset");
   // ==========================================================
   // Register bus answers
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped before handshake");
   AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before handshake");
   cover property (radio_tasks.ed_start);
   cover property ($rose(irq));
   cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule // radio_evt_checker

// *** radio_evt_pkg.sv ***
// Shared constants and types for the radio event routing and interrupt block
package radio_evt_pkg;

   // ==========================================================
   // Register byte addresses
   localparam logic [11:0] ADDR_EVT_STATUS = 12'h100;
   localparam logic [11:0] ADDR_SHORTCUTS = 12'h200;
   localparam logic [11:0] ADDR_INT_SET = 12'h304;
   localparam logic [11:0] ADDR_INT_CLR = 12'h308;
   localparam logic [11:0] ADDR_RSSI_SAMPLE = 12'h548;
   localparam logic [11:0] ADDR_BIT_CMP = 12'h560;

   // ==========================================================
   // Event bit positions, shared by status, set and clear registers
   localparam int EV_READY = 0;
   localparam int EV_RSSI_DONE = 7;
   localparam int EV_BIT_MATCH = 10;
   localparam int EV_CHAN_IDLE = 16;
   localparam int EV_ED_DONE = 14;
   localparam int EV_RATE_UP = 19;
   localparam int EV_TX_READY = 20;
   localparam int EV_RX_READY = 21;
   localparam int EV_PHY_END = 27;
   localparam logic [31:0] EVT_MASK = 32'h18ffd4ff;
   // Events the block raises itself; inputs on these positions are ignored
   localparam logic [31:0] EVT_INTERNAL = 32'h00080480;

   // ==========================================================
   // Shortcut field positions
   localparam int SC_READY_ED_START = 15;
   localparam int SC_ED_DONE_DISABLE = 16;
   localparam int SC_IDLE_STOP = 17;
   localparam int SC_TX_READY_START = 18;
   localparam int SC_RX_READY_START = 19;
   localparam int SC_PHY_END_DISABLE = 20;
   localparam int SC_PHY_END_START = 21;
   localparam logic [31:0] SC_MASK = 32'h003f8000;

   // ==========================================================
   // Reset values and bus answers
   localparam logic [31:0] RST_ZERO = 32'h00000000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {RATE_LOW, RATE_HIGH} rate_mode_e;

   typedef struct packed {
      logic ed_start;
      logic start_radio;
      logic disable_radio;
      logic stop_radio;
   } radio_task_s;

endpackage
